// [general_timer_capture_pwm.sv]
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module general_timer_capture_pwm #(
    parameter int unsigned CNT_W    = 16,
    parameter int unsigned FILT_LEN = 4
) (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire logic [timer_pkg::ADDR_W-1:0]    addr,
    input  wire logic [timer_pkg::BUS_W-1:0]     wdata,
    input  wire logic                            wr_en,
    input  wire logic                            rd_en,
    output logic      [timer_pkg::BUS_W-1:0]     rdata,
    input  wire logic [3:0]                      ch_in,
    output logic      [3:0]                      ch_out,
    output logic      [3:0]                      ch_oe_n,
    input  wire logic                            ext_trigger_input,
    input  wire logic                            itr_in,
    output logic                                 irq,
    output logic      [3:0]                      dma_req,
    output logic                                 trig_out
);
    timer_pkg::ctrl_t  ctrl_q;
    timer_pkg::smc_t   smc_q;
    timer_pkg::dien_t  dien_q;
    timer_pkg::ccm_t   ccm_q;
    timer_pkg::ccen_t  cen_q;
    logic [4:0]        sts_q;
    logic [CNT_W-1:0]  counter_value_q;
    logic [CNT_W-1:0]  counter_value_d;
    logic [CNT_W-1:0]  reload_buf_q;
    logic [CNT_W-1:0]  reload_value_q;
    logic [15:0]       prescale_buf_q;
    logic [15:0]       prescale_value_q;
    logic [15:0]       psc_cnt_q;
    logic              dir_q;
    logic              dir_d;
    logic              wrap;
    logic              cnt_moved_q;
    logic [4:0]        pin_s1_q;
    logic [4:0]        pin_s2_q;
    logic              etr_prev_q;
    logic [2:0]        etr_div_q;
    logic              ch1_prev_q;
    logic              trg_prev_q;
    logic              trig_out_q;

    localparam int unsigned BUS_W_L = timer_pkg::BUS_W;
    logic [BUS_W_L-1:0] rd_mux;
    logic [BUS_W_L-1:0] rdata_q;

    wire [4:0]       filt;
    wire [4:0]       filt_in;
    wire [4:0]       filt_en;
    wire [3:0]       ch_evt;
    wire [3:0]       trg_ch;
    wire [7:0]       trg_src;
    wire [CNT_W-1:0] cc_val [4];
    wire [3:0]       cc_wr;
    wire [3:0]       cc_hit;

    wire wr_ctrl   = wr_en & (addr == timer_pkg::OFF_CTRL);
    wire wr_smc    = wr_en & (addr == timer_pkg::OFF_SMC);
    wire wr_dien   = wr_en & (addr == timer_pkg::OFF_DIEN);
    wire wr_sts    = wr_en & (addr == timer_pkg::OFF_STS);
    wire wr_ccm    = wr_en & (addr == timer_pkg::OFF_CCM);
    wire wr_ccen   = wr_en & (addr == timer_pkg::OFF_CCEN);
    wire wr_cnt    = wr_en & (addr == timer_pkg::OFF_CNT);
    wire wr_psc    = wr_en & (addr == timer_pkg::OFF_PSC);
    wire wr_reload = wr_en & (addr == timer_pkg::OFF_RELOAD);

    // Pins come from outside the clock domain
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
        end
        else
        begin
            pin_s1_q <= {ext_trigger_input, ch_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Polarity then edge divider ahead of the trigger filter
    wire etr_pol_lvl = pin_s2_q[4] ^ smc_q.etr_pol;
    wire etr_rise    = etr_pol_lvl & ~etr_prev_q;
    wire etr_divided = (smc_q.etr_div == 2'h0) ? etr_pol_lvl : etr_div_q[smc_q.etr_div - 2'h1];

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            etr_prev_q <= 1'b0;
            etr_div_q  <= 3'h0;
        end
        else
        begin
            etr_prev_q <= etr_pol_lvl;
            etr_div_q  <= etr_div_q + {2'h0, etr_rise};
        end
    end

    assign filt_in = {etr_divided, pin_s2_q[3:0]};
    assign filt_en = {smc_q.etr_filt_en, ccm_q[3].filt_en, ccm_q[2].filt_en, ccm_q[1].filt_en, ccm_q[0].filt_en};

    // With its filter enabled, level changes only after FILT_LEN equal samples; disabled, it follows the input
    for (genvar k = 0; k < 5; k++)
    begin : gen_filt
        logic [FILT_LEN-1:0] sr_q;
        logic                lvl_q;
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                sr_q  <= '0;
                lvl_q <= 1'b0;
            end
            else
            begin
                sr_q <= {sr_q[FILT_LEN-2:0], filt_in[k]};
                if (!filt_en[k])
                    lvl_q <= filt_in[k];
                else if (&sr_q)
                    lvl_q <= 1'b1;
                else if (~|sr_q)
                    lvl_q <= 1'b0;
            end
        end
        assign filt[k] = lvl_q;
    end

    // Trigger selector; internal trigger bypasses every filter
    wire ch1_double_edge = filt[0] ^ ch1_prev_q;
    assign trg_src = {1'b0, itr_in, filt[4], ch1_double_edge, trg_ch};
    wire trg_lvl   = trg_src[smc_q.trig_sel];
    wire trg_rise  = trg_lvl & ~trg_prev_q;

    wire sm_ext    = smc_q.slave == timer_pkg::SM_EXT_CLK;
    wire sm_gated  = smc_q.slave == timer_pkg::SM_GATED;
    wire rst_trig  = (smc_q.slave == timer_pkg::SM_RESET) & trg_rise;
    wire start_trg = (smc_q.slave == timer_pkg::SM_TRIGGER) & trg_rise;

    wire prescaler_clock = sm_ext ? trg_rise : 1'b1;
    wire run        = ctrl_q.count_en & (~sm_gated | trg_lvl);
    wire psc_wrap   = psc_cnt_q == prescale_value_q;
    // Empty reload stalls the counter
    wire counter_clock = run & prescaler_clock & psc_wrap & (reload_value_q != '0);
    wire uev        = ~ctrl_q.update_disable & (wrap | rst_trig);

    always_comb
    begin
        counter_value_d = counter_value_q;
        dir_d           = dir_q;
        wrap            = 1'b0;
        if (counter_clock)
        begin
            unique case (ctrl_q.count_direction_select)
                timer_pkg::DIR_DOWN:
                begin
                    if (counter_value_q == '0)
                    begin
                        counter_value_d = reload_value_q;
                        wrap            = 1'b1;
                    end
                    else
                        counter_value_d = counter_value_q - 1'b1;
                    dir_d = 1'b0;
                end
                timer_pkg::DIR_CENTER:
                begin
                    if (!dir_q && (counter_value_q < reload_value_q))
                    begin
                        counter_value_d = counter_value_q + 1'b1;
                        wrap            = counter_value_q == reload_value_q - 1'b1;
                        dir_d           = counter_value_q == reload_value_q - 1'b1;
                    end
                    else
                    begin
                        counter_value_d = counter_value_q - 1'b1;
                        wrap            = counter_value_q == {{(CNT_W-1){1'b0}}, 1'b1};
                        dir_d           = counter_value_q > {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                default:
                begin
                    if (counter_value_q == reload_value_q)
                    begin
                        counter_value_d = '0;
                        wrap            = 1'b1;
                    end
                    else
                        counter_value_d = counter_value_q + 1'b1;
                    dir_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            counter_value_q <= '0;
            dir_q           <= 1'b0;
            cnt_moved_q     <= 1'b0;
            psc_cnt_q       <= 16'h0000;
        end
        else
        begin
            cnt_moved_q <= counter_clock | rst_trig | wr_cnt;
            dir_q       <= rst_trig ? 1'b0 : dir_d;
            if (rst_trig)
                counter_value_q <= (ctrl_q.count_direction_select == timer_pkg::DIR_DOWN) ? reload_value_q : '0;
            else if (wr_cnt)
                counter_value_q <= wdata[CNT_W-1:0];
            else
                counter_value_q <= counter_value_d;
            if (rst_trig)
                psc_cnt_q <= 16'h0000;
            else if (run & prescaler_clock)
                psc_cnt_q <= psc_wrap ? 16'h0000 : psc_cnt_q + 16'h0001;
        end
    end

    // Live division period is never disturbed by a write
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prescale_buf_q   <= timer_pkg::PSC_RST;
            prescale_value_q <= timer_pkg::PSC_RST;
            reload_buf_q     <= timer_pkg::RELOAD_RST[CNT_W-1:0];
            reload_value_q   <= timer_pkg::RELOAD_RST[CNT_W-1:0];
        end
        else
        begin
            if (wr_psc)
                prescale_buf_q <= wdata[15:0];
            if (wr_reload)
                reload_buf_q <= wdata[CNT_W-1:0];
            if (uev)
            begin
                prescale_value_q <= prescale_buf_q;
                reload_value_q   <= reload_buf_q;
            end
        end
    end

    for (genvar i = 0; i < 4; i++)
    begin : gen_ch
        timer_pkg::ch_cfg_t cfg;
        timer_pkg::ch_en_t  ce;
        logic [CNT_W-1:0]   cc_q;
        logic               prev_q;
        logic [2:0]         ev_cnt_q;
        logic               ref_q;
        logic               ref_d;
        logic               out_q;
        wire                xmap;
        wire                is_in;
        wire                in_lvl;
        wire                pol_lvl;
        wire                edge_hit;
        wire [2:0]          need;
        wire                cap;
        wire                lt;
        wire                match;

        assign cfg      = ccm_q[i];
        assign ce       = cen_q[i];
        assign xmap     = (i < 2) && (cfg.sel == timer_pkg::SEL_IN_XMAP);
        assign is_in    = (cfg.sel == timer_pkg::SEL_IN) | xmap;
        assign in_lvl   = xmap ? filt[i ^ 1] : filt[i];
        assign pol_lvl  = in_lvl ^ ce.channel_polarity;
        assign edge_hit = pol_lvl & ~prev_q & is_in & ce.en;
        assign need     = (3'h1 << cfg.cap_psc) - 3'h1;
        assign cap      = edge_hit & (ev_cnt_q == need);
        assign lt       = counter_value_q < cc_q;
        assign match    = cnt_moved_q & (counter_value_q == cc_q) & ~is_in;
        assign trg_ch[i] = filt[i] ^ ce.channel_polarity;

        always_comb
        begin
            ref_d = ref_q;
            unique case (cfg.compare_output_mode)
                timer_pkg::OCM_FREEZE:    ref_d = ref_q;
                timer_pkg::OCM_ACT_MATCH: ref_d = match | ref_q;
                timer_pkg::OCM_INA_MATCH: ref_d = ~match & ref_q;
                timer_pkg::OCM_TOGGLE:    ref_d = match ^ ref_q;
                timer_pkg::OCM_FORCE_INA: ref_d = 1'b0;
                timer_pkg::OCM_FORCE_ACT: ref_d = 1'b1;
                timer_pkg::OCM_PWM1:      ref_d = lt;
                timer_pkg::OCM_PWM2:      ref_d = ~lt;
            endcase
        end

        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                cc_q     <= '0;
                prev_q   <= 1'b0;
                ev_cnt_q <= 3'h0;
                ref_q    <= 1'b0;
                out_q    <= 1'b0;
            end
            else
            begin
                prev_q <= pol_lvl;
                ref_q  <= ref_d;
                out_q  <= ref_q ^ ce.channel_polarity;
                if (!is_in)
                    ev_cnt_q <= 3'h0;
                else if (edge_hit)
                    ev_cnt_q <= cap ? 3'h0 : ev_cnt_q + 3'h1;
                // Capture wins over a software write in the same cycle
                if (cap)
                    cc_q <= counter_value_q;
                else if (cc_wr[i])
                    cc_q <= wdata[CNT_W-1:0];
            end
        end

        assign cc_hit[i]  = addr == timer_pkg::OFF_CC[i];
        assign cc_wr[i]   = wr_en & cc_hit[i];
        assign cc_val[i]  = cc_q;
        assign ch_evt[i]  = cap | match;
        assign ch_out[i]  = out_q;
        assign ch_oe_n[i] = ~(ce.en & (cfg.sel == timer_pkg::SEL_OUT));
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q     <= '0;
            smc_q      <= '0;
            dien_q     <= '0;
            ccm_q      <= '0;
            cen_q      <= '0;
            sts_q      <= 5'h00;
            ch1_prev_q <= 1'b0;
            trg_prev_q <= 1'b0;
            trig_out_q <= 1'b0;
        end
        else
        begin
            ch1_prev_q <= filt[0];
            trg_prev_q <= trg_lvl;
            trig_out_q <= uev;
            if (wr_ctrl)
                ctrl_q <= timer_pkg::ctrl_t'(wdata[$bits(timer_pkg::ctrl_t)-1:0]);
            if (start_trg)
                ctrl_q.count_en <= 1'b1;
            if (wr_smc)
                smc_q <= timer_pkg::smc_t'(wdata[$bits(timer_pkg::smc_t)-1:0]);
            if (wr_dien)
                dien_q <= timer_pkg::dien_t'(wdata[$bits(timer_pkg::dien_t)-1:0]);
            if (wr_ccm)
                ccm_q <= timer_pkg::ccm_t'(wdata);
            if (wr_ccen)
                cen_q <= timer_pkg::ccen_t'(wdata[7:0]);
            // Writing zero clears; a new event in that cycle still sets
            sts_q <= (wr_sts ? (sts_q & wdata[4:0]) : sts_q) | {ch_evt, uev};
        end
    end

    assign irq     = |(sts_q & {dien_q.channel_irq_enable, dien_q.upd_ie});
    assign dma_req = sts_q[4:1] & dien_q.dma_en & {4{ctrl_q.channel_dma_select}};

    always_comb
    begin
        rd_mux = '0;
        unique case (addr)
            timer_pkg::OFF_CTRL:   rd_mux = 32'(ctrl_q);
            timer_pkg::OFF_SMC:    rd_mux = 32'(smc_q);
            timer_pkg::OFF_DIEN:   rd_mux = 32'(dien_q);
            timer_pkg::OFF_STS:    rd_mux = 32'(sts_q);
            timer_pkg::OFF_CCM:    rd_mux = 32'(ccm_q);
            timer_pkg::OFF_CCEN:   rd_mux = 32'(cen_q);
            timer_pkg::OFF_CNT:    rd_mux = 32'(counter_value_q);
            timer_pkg::OFF_PSC:    rd_mux = 32'(prescale_buf_q);
            timer_pkg::OFF_RELOAD: rd_mux = 32'(reload_buf_q);
            timer_pkg::OFF_CC[0]:  rd_mux = 32'(cc_val[0]);
            timer_pkg::OFF_CC[1]:  rd_mux = 32'(cc_val[1]);
            timer_pkg::OFF_CC[2]:  rd_mux = 32'(cc_val[2]);
            timer_pkg::OFF_CC[3]:  rd_mux = 32'(cc_val[3]);
            default:               rd_mux = '0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rdata_q <= '0;
        else
            rdata_q <= rd_en ? rd_mux : '0;
    end

    assign rdata    = rdata_q;
    assign trig_out = trig_out_q;
endmodule
`default_nettype wire

// [general_timer_capture_pwm_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module general_timer_capture_pwm_tb;
    logic        ref_clk, rst, wr_en, rd_en, itr_req, ext_trigger_input, itr_in, irq, trig_out;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  ch_in, ch_out, ch_oe_n, dma_req, ch_set;
    logic [1:0]  lag;
    int          err_count, total_checks;

    general_timer_capture_pwm i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ch_in(ch_in), .ch_out(ch_out), .ch_oe_n(ch_oe_n),
        .ext_trigger_input(ext_trigger_input), .itr_in(itr_in), .irq(irq), .dma_req(dma_req),
        .trig_out(trig_out));
    timer_pins_model i_pins (.ref_clk(ref_clk), .ch_set(ch_set), .itr_req(itr_req), .lag(lag),
        .ch_in(ch_in), .ext_trg(ext_trigger_input), .itr(itr_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic pulse_itr(input logic tx);
        @(posedge ref_clk);
        itr_req <= 1'b1;
        @(posedge ref_clk);
        itr_req <= 1'b0;
        #1;
        chk({31'h0, trig_out}, {31'h0, tx});
        idle(4);
    endtask

    task automatic edge_in(input logic lvl);
        @(posedge ref_clk);
        ch_set[1] <= lvl;
        idle(11);
    endtask

    task automatic t_map;
        rd(timer_pkg::OFF_CTRL, v);
        chk(v, 32'h0);
        rd(timer_pkg::OFF_RELOAD, v);
        chk(v, 32'hffff);
        rd(timer_pkg::OFF_PSC, v);
        chk(v, 32'h0);
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h0c, v);
        chk(v, 32'h0);
        chk({28'h0, ch_oe_n}, 32'hf);
    endtask

    // Reset mode on the neighbour trigger forces updates without long waits
    task automatic t_update;
        wr(timer_pkg::OFF_RELOAD, 32'h7);
        wr(timer_pkg::OFF_SMC, 32'h34);
        wr(timer_pkg::OFF_STS, 32'h0);
        pulse_itr(1'b1);
        rd(timer_pkg::OFF_STS, v);
        chk(v & 32'h1, 32'h1);
        wr(timer_pkg::OFF_STS, 32'h0);
        wr(timer_pkg::OFF_CTRL, 32'h8);
        pulse_itr(1'b0);
        rd(timer_pkg::OFF_STS, v);
        chk(v & 32'h1, 32'h0);
    endtask

    task automatic t_pwm;
        logic [2:0]  md [11] = '{3'h6, 3'h7, 3'h6, 3'h6, 3'h6, 3'h4, 3'h5, 3'h0, 3'h2, 3'h1, 3'h3};
        logic [1:0]  dr [11] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
        int          ps [11] = '{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0};
        int          wn [11] = '{16, 16, 16, 28, 32, 8, 8, 8, 8, 8, 16};
        int          ex [11] = '{10, 6, 10, 18, 20, 0, 8, 8, 0, 8, 8};
        logic [31:0] n;
        wr(timer_pkg::OFF_CCEN, 32'h1);
        wr(timer_pkg::OFF_CC[0], 32'h5);
        rd(timer_pkg::OFF_CC[0], v);
        chk(v, 32'h5);
        chk({28'h0, ch_oe_n}, 32'he);
        for (int i = 0; i < 11; i++)
        begin
            wr(timer_pkg::OFF_CCM, {27'h0, md[i], 2'h0});
            wr(timer_pkg::OFF_PSC, ps[i]);
            wr(timer_pkg::OFF_CTRL, {29'h0, dr[i], 1'b1});
            pulse_itr(1'b1);
            idle(20);
            n = 32'h0;
            repeat (wn[i])
            begin
                @(posedge ref_clk);
                #1;
                n = n + {31'h0, ch_out[0]};
            end
            chk(n, ex[i]);
        end
    endtask

    task automatic t_capture;
        wr(timer_pkg::OFF_CTRL, 32'h10);
        wr(timer_pkg::OFF_CNT, 32'h1234);
        wr(timer_pkg::OFF_CCM, 32'h100);
        wr(timer_pkg::OFF_CCEN, 32'h4);
        wr(timer_pkg::OFF_DIEN, 32'h44);
        wr(timer_pkg::OFF_STS, 32'h0);
        lag <= 2'h2;
        edge_in(1'b1);
        rd(timer_pkg::OFF_STS, v);
        chk(v & 32'h4, 32'h4);
        rd(timer_pkg::OFF_CC[1], v);
        chk(v, 32'h1234);
        chk({31'h0, irq}, 32'h1);
        chk({28'h0, dma_req}, 32'h2);
        wr(timer_pkg::OFF_STS, 32'h0);
        #1;
        chk({31'h0, irq}, 32'h0);
        wr(timer_pkg::OFF_CCEN, 32'hc);
        wr(timer_pkg::OFF_CNT, 32'h42);
        edge_in(1'b0);
        rd(timer_pkg::OFF_CC[1], v);
        chk(v, 32'h42);
        wr(timer_pkg::OFF_CCEN, 32'h4);
        wr(timer_pkg::OFF_CCM, 32'h2100);
        wr(timer_pkg::OFF_STS, 32'h0);
        edge_in(1'b1);
        edge_in(1'b0);
        rd(timer_pkg::OFF_STS, v);
        chk(v & 32'h4, 32'h0);
        edge_in(1'b1);
        rd(timer_pkg::OFF_STS, v);
        chk(v & 32'h4, 32'h4);
        wr(timer_pkg::OFF_DIEN, 32'h0);
    endtask

    task automatic t_ext;
        wr(timer_pkg::OFF_CNT, 32'h0);
        wr(timer_pkg::OFF_SMC, 32'h29);
        wr(timer_pkg::OFF_CTRL, 32'h1);
        repeat (6)
        begin
            @(posedge ref_clk);
            ch_set[3] <= ~ch_set[3];
            idle(8);
        end
        rd(timer_pkg::OFF_CNT, v);
        chk(v, 32'h3);
    endtask

    initial
    begin
        {rst, wr_en, rd_en, itr_req} = 4'h8;
        {addr, wdata, ch_set, lag} = '0;
        {err_count, total_checks} = '0;
        idle(3);
        rst <= 1'b0;
        t_map;
        t_update;
        t_pwm;
        t_capture;
        t_ext;
        give_verdict;
    end

    // Whole run needs under a thousand cycles
    initial
    begin
        idle(20000);
        err_count++;
        give_verdict;
    end
endmodule
`default_nettype wire

// [timer_pins_model.sv]
`timescale 1ns/100ps
`default_nettype none
module timer_pins_model (
    input  wire logic       ref_clk,
    input  wire logic [3:0] ch_set,
    input  wire logic       itr_req,
    input  wire logic [1:0] lag,
    output logic      [3:0] ch_in,
    output logic            ext_trg,
    output logic            itr
);
    logic [3:0] dly_q [3];
    logic       req_q;

    // Slow sources: pins follow the command up to three cycles late
    always_ff @(posedge ref_clk)
    begin
        dly_q[0] <= ch_set;
        dly_q[1] <= dly_q[0];
        dly_q[2] <= dly_q[1];
        req_q    <= itr_req;
    end
    assign ch_in   = (lag == 2'h0) ? ch_set : dly_q[lag-2'h1];
    assign itr     = itr_req && !req_q;
    // Trigger pin shares channel four's source
    assign ext_trg = ch_set[3];
endmodule
`default_nettype wire

// [timer_pkg.sv]
`default_nettype none
package timer_pkg;
    localparam int unsigned BUS_W = 32;
    localparam int unsigned ADDR_W = 8;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SMC = 8'h04;
    localparam logic [7:0] OFF_DIEN = 8'h08;
    localparam logic [7:0] OFF_STS = 8'h10;
    localparam logic [7:0] OFF_CCM = 8'h18;
    localparam logic [7:0] OFF_CCEN = 8'h20;
    localparam logic [7:0] OFF_CNT = 8'h24;
    localparam logic [7:0] OFF_PSC = 8'h28;
    localparam logic [7:0] OFF_RELOAD = 8'h2c;
    localparam logic [7:0] OFF_CC [4] = '{8'h34, 8'h38, 8'h3c, 8'h40};

    localparam logic [31:0] RELOAD_RST = 32'hffff_ffff;
    localparam logic [15:0] PSC_RST = 16'h0000;

    typedef enum logic [1:0] {
        DIR_UP     = 2'b00,
        DIR_DOWN   = 2'b01,
        DIR_CENTER = 2'b10
    } dir_mode_t;

    typedef enum logic [2:0] {
        SM_OFF     = 3'h0,
        SM_EXT_CLK = 3'h1,
        SM_RESET   = 3'h4,
        SM_GATED   = 3'h5,
        SM_TRIGGER = 3'h6
    } slave_mode_t;

    typedef enum logic [2:0] {
        TRG_CH1       = 3'h0,
        TRG_CH2       = 3'h1,
        TRG_CH3       = 3'h2,
        TRG_CH4       = 3'h3,
        TRG_CH1_EDGES = 3'h4,
        TRG_ETR       = 3'h5,
        TRG_ITR       = 3'h6
    } trig_sel_t;

    typedef enum logic [2:0] {
        OCM_FREEZE    = 3'h0,
        OCM_ACT_MATCH = 3'h1,
        OCM_INA_MATCH = 3'h2,
        OCM_TOGGLE    = 3'h3,
        OCM_FORCE_INA = 3'h4,
        OCM_FORCE_ACT = 3'h5,
        OCM_PWM1      = 3'h6,
        OCM_PWM2      = 3'h7
    } ocm_t;

    typedef enum logic [1:0] {
        SEL_OUT     = 2'h0,
        SEL_IN      = 2'h1,
        SEL_IN_XMAP = 2'h2
    } ch_sel_t;

    typedef struct packed {
        logic      channel_dma_select;
        logic      update_disable;
        dir_mode_t count_direction_select;
        logic      count_en;
    } ctrl_t;

    typedef struct packed {
        logic        etr_filt_en;
        logic [1:0]  etr_div;
        logic        etr_pol;
        trig_sel_t   trig_sel;
        slave_mode_t slave;
    } smc_t;

    typedef struct packed {
        logic [3:0] dma_en;
        logic [3:0] channel_irq_enable;
        logic       upd_ie;
    } dien_t;

    typedef struct packed {
        logic       filt_en;
        logic [1:0] cap_psc;
        ocm_t       compare_output_mode;
        ch_sel_t    sel;
    } ch_cfg_t;

    typedef struct packed {
        logic channel_polarity;
        logic en;
    } ch_en_t;

    typedef ch_cfg_t [3:0] ccm_t;
    typedef ch_en_t [3:0] ccen_t;
endpackage
`default_nettype wire

// [timer_props.sv]
`timescale 1ns/100ps
`default_nettype none
module timer_props #(
    parameter int unsigned CNT_W = 16
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    input wire logic [3:0]  ch_out,
    input wire logic [3:0]  ch_oe_n,
    input wire logic        irq,
    input wire logic [3:0]  dma_req,
    input wire logic        trig_out
);
    localparam logic [31:0] MASK = 32'hffff_ffff >> (32 - CNT_W);
    logic [31:0] ccm_q;
    logic [31:0] cc1_q;
    logic [15:0] pre_q;
    logic [8:0]  dien_q;
    logic [7:0]  ccen_q;
    logic        dsel_q;
    logic        ud_q;
    logic        cc_ok_q;
    logic [1:0]  quiet_q;
    logic [3:0]  oe_exp;
    wire         wr_cfg = wr_en && (addr == timer_pkg::OFF_CCM || addr == timer_pkg::OFF_CCEN);
    wire         wr_cc1 = wr_en && addr == timer_pkg::OFF_CC[0];
    wire         out0   = ccm_q[1:0] == 2'h0;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            {ccm_q, cc1_q, pre_q, dien_q, ccen_q, dsel_q, ud_q} <= '0;
        end
        else if (wr_en)
        begin
            if (addr == timer_pkg::OFF_CCM) ccm_q <= wdata;
            if (addr == timer_pkg::OFF_CCEN) ccen_q <= wdata[7:0];
            if (addr == timer_pkg::OFF_DIEN) dien_q <= wdata[8:0];
            if (addr == timer_pkg::OFF_CTRL) dsel_q <= wdata[4];
            if (addr == timer_pkg::OFF_CTRL) ud_q <= wdata[3];
            if (addr == timer_pkg::OFF_PSC) pre_q <= wdata[15:0];
            if (wr_cc1) cc1_q <= wdata;
        end
    end

    // Input mode may capture, so the written value is trusted only while output
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst) cc_ok_q <= 1'b1;
        else cc_ok_q <= out0 && (cc_ok_q || wr_cc1);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst) quiet_q <= 2'h0;
        else if (wr_cfg) quiet_q <= 2'h0;
        else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            oe_exp[i] = ccen_q[2*i] && ccm_q[8*i+:2] == 2'h0;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_pre_readback: assert property (rd_en && addr == timer_pkg::OFF_PSC |=> rdata == {16'h0, pre_q})
        else $error("prescale readback differs from last write");
    chk_cc1_readback: assert property (rd_en && addr == timer_pkg::OFF_CC[0] && cc_ok_q |=> rdata == (cc1_q & MASK))
        else $error("channel one compare readback differs");
    chk_oe_cfg: assert property (ch_oe_n == ~oe_exp)
        else $error("pin drive does not follow channel setup");
    chk_irq_needs_en: assert property (irq |-> dien_q[4:0] != 5'h0)
        else $error("interrupt without any enable");
    chk_dma_needs_sel: assert property (dma_req != 4'h0 |-> dsel_q && (dma_req & ~dien_q[8:5]) == 4'h0)
        else $error("dma request without its enables");
    chk_force_level: assert property (quiet_q == 2'h3 && out0 && ccm_q[4:3] == 2'h2 |-> ch_out[0] == (ccm_q[2] ^ ccen_q[1]))
        else $error("forced level wrong on channel one");
    chk_trig_held_off: assert property (ud_q && !(wr_en && addr == timer_pkg::OFF_CTRL) |=> !trig_out)
        else $error("trigger output while updates are disabled");
    chk_irq_off_write: assert property (wr_en && addr == timer_pkg::OFF_DIEN && wdata[4:0] == 5'h0 |=> !irq)
        else $error("interrupt stays after enables cleared");
endmodule

bind general_timer_capture_pwm timer_props #(.CNT_W(CNT_W)) i_props (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ch_out(ch_out), .ch_oe_n(ch_oe_n),
    .irq(irq), .dma_req(dma_req), .trig_out(trig_out));
`default_nettype wire
